// File: common/fsv_pkg.sv
// Package for the fault status and voltage-code register bank.
// Assumes one 250 MHz clock shared with the serial port register engine.
package fsv_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] FAULT_STATUS_TWO_ADDR = 8'h42;
   localparam logic [7:0] VOLTAGE_CODE_CONTROL_ADDR = 8'h43;
   localparam logic [7:0] FAULT_STATUS_TWO_RESET = 8'h00;
   localparam logic [7:0] VOLTAGE_CODE_CONTROL_RESET = 8'h1F;
   localparam logic [7:0] ALARM_LIMIT_ADDR = 8'h7A;
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int SUPPLY_BIT = 0;
   localparam int OVERTEMP_BIT = 1;
   localparam int FAN_ONE_BIT = 2;
   localparam int FOURTH_BIT = 5;
   localparam int DIODE_A_BIT = 6;
   localparam int TOP_CODE_BIT = 5;
   localparam int THRESHOLD_BIT = 6;
   localparam int PIN_SELECT_BIT = 7;
   localparam int CODE_WIDTH = 6;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLOCK_PERIOD_PS = 4000;
   localparam int CODE_INTERVAL_US = 11;
   localparam int CODE_INTERVAL_CYCLES =
      (CODE_INTERVAL_US * 1000000) / CLOCK_PERIOD_PS;
   localparam int ALARM_UNIT_CYCLES = 250;
   // ----------------------------------------
   // Modes of the multi-purpose fourth-fan pin
   // ----------------------------------------
   typedef enum logic [1:0] {
      FSV_PIN_TACH = 2'h0,
      FSV_PIN_GPO = 2'h1,
      FSV_PIN_GPI = 2'h2,
      FSV_PIN_TIMER = 2'h3
   } fsv_pin_mode_e;
   // Fault conditions, all levels from the measurement engines
   typedef struct packed {
      logic supplyOutOfLimit;
      logic overtempActive;
      logic overtempBelowHyst;
      logic [3:0] fanStall;
      logic [2:0] fanDriveOff;
      logic [1:0] diodeFault;
   } fsv_cond_s;
endpackage

// File: src/fsv_fault_status_and_vid_regs.sv
// Second fault status register and voltage-code control register.
// Assumes the serial port engine issues one-cycle read and write strobes
// on the same clock, and the measurement engines give level conditions.
//
// How it works
// - Supply fault latches bit 0, read clears if ended
// - Code-pin mode: bit 0 flags code change
// - Any status flag, code change included, drives the alert request
// - Overtemp latches bit 1, read clears below hysteresis
// - Bits 2-4 fan stalls, clear while drive off
// - Tach mode: bit 5 fan four, gated drive three
// - GPIO mode: bit 5 drives or reads pin
// - Timer mode: bit 5 when alarm time exceeds limit
// - Bits 6-7 flag diode open or short
// - Code bits follow pins from reset onward
// - GPO mode makes code bits writable outputs
// - Code bit 5 reads zero unless pin select or GPO mode
// - Bit 6 selects the input threshold
// - Pin select resets to supply input
// - Summary flag is OR of all status bits
`timescale 1ns/1ps
module fsv_fault_status_and_vid_regs #(
   parameter int INTERVAL_CYCLES = fsv_pkg::CODE_INTERVAL_CYCLES,
   parameter int UNIT_CYCLES = fsv_pkg::ALARM_UNIT_CYCLES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire fsv_pkg::fsv_cond_s cond,
   input wire fsv_pkg::fsv_pin_mode_e pinMode,
   input wire logic codeGpoEnable,
   input wire logic [7:0] alarmLimit,
   input wire logic [5:0] codePinIn,
   output logic [5:0] codePinOut,
   output logic [5:0] codePinOe,
   input wire logic generalIoSixIn,
   output logic generalIoSixOut,
   output logic generalIoSixOe,
   input wire logic thermalAlarmPin,
   output logic codeInputThresholdSelect,
   output logic sharedPinSelect,
   output logic anySecondStatusFlag,
   output logic alertRequest
);
   import fsv_pkg::*;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [7:0] pinRaw;
   logic [7:0] sync1_ff, sync2_ff, sync3_ff, pinFilt_ff;
   logic [7:0] agree;
   assign pinRaw = {thermalAlarmPin, generalIoSixIn, codePinIn};
   assign agree = ~(sync2_ff ^ sync3_ff);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_ff <= 8'h1F;
         sync2_ff <= 8'h1F;
         sync3_ff <= 8'h1F;
         pinFilt_ff <= 8'h1F;
      end else begin
         sync1_ff <= pinRaw;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         pinFilt_ff <= (sync3_ff & agree) | (pinFilt_ff & ~agree);
      end
   end

   logic [5:0] codeFilt;
   logic thermSync, gpioSync;
   assign codeFilt = pinFilt_ff[5:0];
   assign gpioSync = pinFilt_ff[6];
   assign thermSync = pinFilt_ff[7];

   // ----------------------------------------
   // Voltage-code control register
   // ----------------------------------------
   logic [7:0] codeCtl_ff;
   logic wrCode, wrStat, rdStat;
   assign wrCode = regWr && (regAddr == VOLTAGE_CODE_CONTROL_ADDR);
   assign wrStat = regWr && (regAddr == FAULT_STATUS_TWO_ADDR);
   assign rdStat = regRd && (regAddr == FAULT_STATUS_TWO_ADDR);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         codeCtl_ff <= VOLTAGE_CODE_CONTROL_RESET;
      end else if (wrCode) begin
         codeCtl_ff[PIN_SELECT_BIT] <= regWrData[PIN_SELECT_BIT];
         codeCtl_ff[THRESHOLD_BIT] <= regWrData[THRESHOLD_BIT];
         if (codeGpoEnable) begin
            codeCtl_ff[CODE_WIDTH-1:0] <= regWrData[CODE_WIDTH-1:0];
         end
      end
   end

   assign codeInputThresholdSelect = codeCtl_ff[THRESHOLD_BIT];
   assign sharedPinSelect = codeCtl_ff[PIN_SELECT_BIT];
   // drive code pins in GPO mode
   assign codePinOut = codeCtl_ff[CODE_WIDTH-1:0];
   assign codePinOe = {CODE_WIDTH{codeGpoEnable}};

   // Top code bit only counts when the shared pin is routed to it
   logic [5:0] codeSeen;
   logic [7:0] codeRead;
   assign codeSeen = {codeFilt[TOP_CODE_BIT] & sharedPinSelect,
                      codeFilt[4:0]};
   assign codeRead = codeGpoEnable ? codeCtl_ff :
      {codeCtl_ff[7:6], codeSeen};

   // ----------------------------------------
   // Code change detection
   // ----------------------------------------
   logic [11:0] intervalCnt_ff;
   logic [5:0] codeSnap_ff;
   logic intervalTick, codeChanged;
   assign intervalTick = (intervalCnt_ff == 12'(INTERVAL_CYCLES - 1));
   // compare with snapshot one interval old
   assign codeChanged = intervalTick && (codeSeen != codeSnap_ff);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         intervalCnt_ff <= 12'h000;
         codeSnap_ff <= 6'h1F;
      end else if (intervalTick) begin
         intervalCnt_ff <= 12'h000;
         codeSnap_ff <= codeSeen;
      end else begin
         intervalCnt_ff <= intervalCnt_ff + 12'h001;
      end
   end

   // ----------------------------------------
   // Alarm assertion timer
   // ----------------------------------------
   // Saturating count in units; long alarms pin at full scale
   logic [15:0] unitCnt_ff;
   logic [7:0] alarmAcc_ff;
   logic unitTick, timerMode, alarmExceeded;
   assign timerMode = (pinMode == FSV_PIN_TIMER);
   assign unitTick = (unitCnt_ff == 16'(UNIT_CYCLES - 1));
   assign alarmExceeded = (alarmAcc_ff > alarmLimit);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         unitCnt_ff <= 16'h0000;
         alarmAcc_ff <= 8'h00;
      end else if (!timerMode) begin
         unitCnt_ff <= 16'h0000;
         alarmAcc_ff <= 8'h00;
      end else if (thermSync) begin
         unitCnt_ff <= unitTick ? 16'h0000 : unitCnt_ff + 16'h0001;
         if (unitTick && alarmAcc_ff != 8'hFF) begin
            alarmAcc_ff <= alarmAcc_ff + 8'h01;
         end
      end
   end

   // ----------------------------------------
   // Fault status register
   // ----------------------------------------
   logic [7:0] status_ff, nxt_status, setMask, keepOnRead, readView;
   logic gpoBit_ff, stallFour;
   assign stallFour = cond.fanStall[3] & ~cond.fanDriveOff[2];

   always_comb begin
      setMask = 8'h00;
      keepOnRead = 8'h00;
      // supply fault when pin is supply input
      // code change when pin is code bit
      setMask[SUPPLY_BIT] = sharedPinSelect ? codeChanged :
         cond.supplyOutOfLimit;
      keepOnRead[SUPPLY_BIT] = setMask[SUPPLY_BIT];
      setMask[OVERTEMP_BIT] = cond.overtempActive;
      keepOnRead[OVERTEMP_BIT] = ~cond.overtempBelowHyst;
      setMask[4:2] = cond.fanStall[2:0] & ~cond.fanDriveOff;
      keepOnRead[4:2] = setMask[4:2];
      // fan four gated by drive three
      setMask[FOURTH_BIT] = (pinMode == FSV_PIN_TACH) ? stallFour :
         (timerMode && alarmExceeded);
      keepOnRead[FOURTH_BIT] = setMask[FOURTH_BIT];
      setMask[7:6] = cond.diodeFault;
      keepOnRead[7:6] = setMask[7:6];
      // Set beats a clear in the same cycle
      nxt_status = (rdStat ? (status_ff & keepOnRead) : status_ff)
         | setMask;
      nxt_status[4:2] = nxt_status[4:2] & ~cond.fanDriveOff;
      if (pinMode == FSV_PIN_TACH && cond.fanDriveOff[2]) begin
         nxt_status[FOURTH_BIT] = 1'b0;
      end
      if (pinMode == FSV_PIN_GPO || pinMode == FSV_PIN_GPI) begin
         nxt_status[FOURTH_BIT] = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= FAULT_STATUS_TWO_RESET;
      end else begin
         status_ff <= nxt_status;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gpoBit_ff <= 1'b0;
      end else if (wrStat && pinMode == FSV_PIN_GPO) begin
         gpoBit_ff <= regWrData[FOURTH_BIT];
      end
   end

   assign generalIoSixOut = gpoBit_ff;
   assign generalIoSixOe = (pinMode == FSV_PIN_GPO);

   // bit 5 shows pin or driven level
   always_comb begin
      readView = status_ff;
      if (pinMode == FSV_PIN_GPO) begin
         readView[FOURTH_BIT] = gpoBit_ff;
      end else if (pinMode == FSV_PIN_GPI) begin
         readView[FOURTH_BIT] = gpioSync;
      end
   end

   assign anySecondStatusFlag = |status_ff;
   assign alertRequest = |status_ff;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         unique case (regAddr)
            FAULT_STATUS_TWO_ADDR: regRdData <= readView;
            VOLTAGE_CODE_CONTROL_ADDR: regRdData <= codeRead;
            default: regRdData <= 8'h00;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_supply_set;
      (!sharedPinSelect && cond.supplyOutOfLimit) |=> status_ff[0];
   endproperty
   a_supply_set: assert property (p_supply_set)
      else $error("supply fault not latched");
   property p_supply_hold;
      (status_ff[0] && !rdStat) |=> status_ff[0];
   endproperty
   a_supply_hold: assert property (p_supply_hold)
      else $error("status bit 0 cleared without read");
   property p_code_change;
      (sharedPinSelect && intervalTick && codeSeen != codeSnap_ff)
         |=> status_ff[0] ##0 alertRequest;
   endproperty
   a_code_change: assert property (p_code_change)
      else $error("code change not flagged");
   property p_overtemp_keep;
      (status_ff[1] && !cond.overtempBelowHyst) |=> status_ff[1];
   endproperty
   a_overtemp_keep: assert property (p_overtemp_keep)
      else $error("overtemp flag cleared above hysteresis");
   property p_fan_off;
      cond.fanDriveOff[0] |=> !status_ff[2];
   endproperty
   a_fan_off: assert property (p_fan_off)
      else $error("fan one flag with drive off");
   property p_gpo_drive;
      (wrStat && pinMode == FSV_PIN_GPO)
         |=> generalIoSixOut == $past(regWrData[5]);
   endproperty
   a_gpo_drive: assert property (p_gpo_drive)
      else $error("general output level wrong");
   property p_diode;
      cond.diodeFault[1] |=> status_ff[7];
   endproperty
   a_diode: assert property (p_diode)
      else $error("diode b fault not latched");
   property p_top_bit;
      (regRd && regAddr == VOLTAGE_CODE_CONTROL_ADDR && !codeGpoEnable
         && !sharedPinSelect) |=> !regRdData[5];
   endproperty
   a_top_bit: assert property (p_top_bit)
      else $error("code bit 5 read nonzero");
   property p_summary;
      $rose(status_ff[6]) |-> anySecondStatusFlag;
   endproperty
   a_summary: assert property (p_summary)
      else $error("summary flag missing");
   c_code_change: cover property (codeChanged && sharedPinSelect);
   c_read_clear: cover property (rdStat && status_ff[1] ##1 !status_ff[1]);
   c_timer: cover property (timerMode && status_ff[5]);
endmodule

// File: sim/fsv_host_model.sv
// Host side model of the register port, issuing single byte cycles.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module fsv_host_model (
   input wire logic clock,
   input wire logic [7:0] regRdData,
   output logic [7:0] regAddr,
   output logic regWr,
   output logic regRd,
   output logic [7:0] regWrData
);
   initial begin
      regAddr = 8'hFF;
      regWr = 1'b0;
      regRd = 1'b0;
      regWrData = 8'hFF;
   end
   // Idle bus shows inverted address; write data is inverted after a write, kept after a read
   task automatic wrReg(input logic [7:0] addr, input logic [7:0] data);
      @(posedge clock);
      #1;
      regAddr = addr;
      regWrData = data;
      regWr = 1'b1;
      @(posedge clock);
      #1;
      regWr = 1'b0;
      regAddr = ~addr;
      regWrData = ~data;
   endtask
   task automatic rdReg(input logic [7:0] addr, output logic [7:0] data);
      @(posedge clock);
      #1;
      regAddr = addr;
      regRd = 1'b1;
      @(posedge clock);
      #1;
      regRd = 1'b0;
      regAddr = ~addr;
      data = regRdData;
   endtask
endmodule

// File: sim/fsv_fault_status_and_vid_regs_bench.sv
// Self-checking bench for the status and voltage-code register bank.
// Assumes short interval and alarm unit parameters to keep runs brief.
`timescale 1ns/1ps
module fsv_fault_status_and_vid_regs_bench;
   import fsv_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] regAddr, regWrData, regRdData, alarmLimit = 8'h03;
   logic regWr, regRd, codeGpoEnable = 1'b0, generalIoSixIn = 1'b0;
   fsv_cond_s cond = '0;
   fsv_pin_mode_e pinMode = FSV_PIN_TACH;
   logic [5:0] codePinIn = 6'h1F, codePinOut, codePinOe, pins;
   logic thermalAlarmPin = 1'b0;
   logic generalIoSixOut, generalIoSixOe, codeInputThresholdSelect;
   logic sharedPinSelect, anySecondStatusFlag, alertRequest;
   logic [7:0] d, e;
   logic [7:0] expQ[$];
   int errors = 0;
   int cmp_count = 0;
   always #2 clock = ~clock;
   fsv_fault_status_and_vid_regs #(.INTERVAL_CYCLES(16), .UNIT_CYCLES(4))
   fsv_fault_status_and_vid_regs_inst (
      .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWr(regWr),
      .regRd(regRd), .regWrData(regWrData), .regRdData(regRdData),
      .cond(cond), .pinMode(pinMode), .codeGpoEnable(codeGpoEnable),
      .alarmLimit(alarmLimit), .codePinIn(codePinIn),
      .codePinOut(codePinOut), .codePinOe(codePinOe),
      .generalIoSixIn(generalIoSixIn), .generalIoSixOut(generalIoSixOut),
      .generalIoSixOe(generalIoSixOe), .thermalAlarmPin(thermalAlarmPin),
      .codeInputThresholdSelect(codeInputThresholdSelect),
      .sharedPinSelect(sharedPinSelect),
      .anySecondStatusFlag(anySecondStatusFlag),
      .alertRequest(alertRequest));
   fsv_host_model fsv_host_model_inst (
      .clock(clock), .regRdData(regRdData), .regAddr(regAddr),
      .regWr(regWr), .regRd(regRd), .regWrData(regWrData));
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] x);
      logic [7:0] v;
      fsv_host_model_inst.rdReg(a, v);
      check(v, x);
   endtask
   // Two reads after settling drop every flag whose condition has ended
   task automatic flush();
      cyc(40);
      fsv_host_model_inst.rdReg(FAULT_STATUS_TWO_ADDR, d);
      fsv_host_model_inst.rdReg(FAULT_STATUS_TWO_ADDR, d);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      repeat (50000) @(posedge clock);
      errors++;
      end_of_test();
   end
   initial begin
      void'($urandom(32'h88A96713));
      cyc(10);
      rst_n = 1'b1;
      cyc(8);
      rdChk(VOLTAGE_CODE_CONTROL_ADDR, 8'h1F);
      check({sharedPinSelect, codeInputThresholdSelect}, 8'h00);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h00);
      rdChk(8'h7B, 8'h00);
      pins = 6'($urandom);
      codePinIn = pins;
      cyc(8);
      rdChk(VOLTAGE_CODE_CONTROL_ADDR, {3'b000, pins[4:0]});
      fsv_host_model_inst.wrReg(VOLTAGE_CODE_CONTROL_ADDR, 8'hC0);
      check({sharedPinSelect, codeInputThresholdSelect}, 8'h03);
      rdChk(VOLTAGE_CODE_CONTROL_ADDR, {2'b11, pins});
      $display("test code register done");
      flush();
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h00);
      codePinIn = pins ^ 6'h20;
      cyc(40);
      check({7'h0, alertRequest}, 8'h01);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h01);
      cyc(40);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h00);
      $display("test code change done");
      fsv_host_model_inst.wrReg(VOLTAGE_CODE_CONTROL_ADDR, 8'h40);
      flush();
      cond.supplyOutOfLimit = 1'b1;
      cyc(3);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h01);
      check({7'h0, anySecondStatusFlag}, 8'h01);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h01);
      cond.supplyOutOfLimit = 1'b0;
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h01);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h00);
      check({7'h0, anySecondStatusFlag}, 8'h00);
      cond.overtempActive = 1'b1;
      cyc(3);
      cond.overtempActive = 1'b0;
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h02);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h02);
      cond.overtempBelowHyst = 1'b1;
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h02);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h00);
      $display("test supply and overtemp done");
      repeat (8) begin
         cond.fanStall = 4'($urandom);
         cond.fanDriveOff = 3'($urandom);
         cond.diodeFault = 2'($urandom);
         cond.supplyOutOfLimit = 1'($urandom);
         e = {cond.diodeFault, cond.fanStall[3] & ~cond.fanDriveOff[2],
              cond.fanStall[2:0] & ~cond.fanDriveOff, 1'b0,
              cond.supplyOutOfLimit};
         expQ.push_back(e);
         expQ.push_back(e);
         cyc(3);
         rdChk(FAULT_STATUS_TWO_ADDR, expQ.pop_front());
         cond.fanStall = 4'h0;
         cond.diodeFault = 2'h0;
         cond.supplyOutOfLimit = 1'b0;
         rdChk(FAULT_STATUS_TWO_ADDR, expQ.pop_front());
         rdChk(FAULT_STATUS_TWO_ADDR, 8'h00);
      end
      $display("test fan and diode done");
      pinMode = FSV_PIN_GPO;
      fsv_host_model_inst.wrReg(FAULT_STATUS_TWO_ADDR, 8'h20);
      check({generalIoSixOut, generalIoSixOe, anySecondStatusFlag}, 8'h06);
      fsv_host_model_inst.wrReg(FAULT_STATUS_TWO_ADDR, 8'h00);
      check({7'h0, generalIoSixOut}, 8'h00);
      pinMode = FSV_PIN_GPI;
      generalIoSixIn = 1'b1;
      cyc(6);
      check({7'h0, generalIoSixOe}, 8'h00);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h20);
      generalIoSixIn = 1'b0;
      cyc(6);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h00);
      $display("test general io done");
      pinMode = FSV_PIN_TIMER;
      thermalAlarmPin = 1'b1;
      cyc(6);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h00);
      cyc(30);
      rdChk(FAULT_STATUS_TWO_ADDR, 8'h20);
      thermalAlarmPin = 1'b0;
      pinMode = FSV_PIN_TACH;
      flush();
      $display("test alarm timer done");
      codeGpoEnable = 1'b1;
      fsv_host_model_inst.wrReg(VOLTAGE_CODE_CONTROL_ADDR, 8'hAA);
      check({2'b00, codePinOut}, 8'h2A);
      check({2'b00, codePinOe}, 8'h3F);
      rdChk(VOLTAGE_CODE_CONTROL_ADDR, 8'hAA);
      codeGpoEnable = 1'b0;
      fsv_host_model_inst.wrReg(VOLTAGE_CODE_CONTROL_ADDR, 8'h95);
      check({2'b00, codePinOut}, 8'h2A);
      check({2'b00, codePinOe}, 8'h00);
      check({sharedPinSelect, codeInputThresholdSelect}, 8'h02);
      $display("test code outputs done");
      end_of_test();
   end
endmodule
